// ### rtl/acqsq_pkg.sv
// Package with register map, field layouts and timing for the acquisition sequencer
package acqsq_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_BURST = 8'h08;
  localparam logic [7:0] ADDR_PERIOD = 8'h0C;
  localparam logic [7:0] ADDR_ROI = 8'h10;
  localparam logic [7:0] ADDR_EXPO = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_BLOCK = 8'h1C;
  localparam logic [7:0] ADDR_TALLY = 8'h20;
  // Command register bit positions
  localparam int CMD_BEGIN_BIT = 0;
  localparam int CMD_FINISH_BIT = 1;
  localparam int CMD_CANCEL_BIT = 2;
  // Acquisition modes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_BURST = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;
  // Burst frame total limits
  localparam logic [7:0] BURST_MIN = 8'h01;
  localparam logic [7:0] BURST_RESET = 8'h01;
  // Timing: one sensor line and the longest frame period
  localparam int CLK_PERIOD_NS = 8;
  localparam int LINE_TIME_NS = 20000;
  localparam int LINE_CYCLES = LINE_TIME_NS / CLK_PERIOD_NS;
  localparam int MAX_PERIOD_NS = 500000000;
  localparam int MAX_PERIOD_LINES_I = MAX_PERIOD_NS / LINE_TIME_NS;
  localparam logic [15:0] MAX_PERIOD_LINES = 16'(MAX_PERIOD_LINES_I);
  // Reset values of line based settings
  localparam logic [15:0] PERIOD_RESET = 16'h0800;
  localparam logic [15:0] ROI_RESET = 16'h0440;
  localparam logic [15:0] EXPO_RESET = 16'h0100;
  // Control register layout, LSB first: mode, start, end, frame trigger, paired
  typedef struct packed {
    logic paired_exposure_mode;
    logic frame_trig_en;
    logic end_trig_en;
    logic start_trig_en;
    logic [1:0] mode;
  } acqsq_ctrl_t;
  localparam acqsq_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, MODE_CONT};
  // External trigger pulses from the trigger selection logic
  typedef struct packed {
    logic start_trig;
    logic end_trig;
    logic frame_trig;
  } acqsq_trig_t;
  // Status flags driven to the sensor and stream logic
  typedef struct packed {
    logic frame_out;
    logic reading_out;
    logic exposing;
    logic frame_window_flag;
    logic arm_wait_flag;
    logic capture_allowed_flag;
  } acqsq_status_t;
  localparam acqsq_status_t STATUS_RESET = '0;
endpackage

// ### rtl/acqsq_top.sv
// Acquisition sequencer with AXI4-Lite register access
//
// Function
// - One-shot mode: start enables capture, one frame is output, capture then clears.
// - Block number increments per accepted start, resets on an end command, not in paired mode.
// - Burst mode outputs the programmed frame total then stops by itself.
// - Burst frame total accepts 1 to 255.
// - Continuous mode streams frames at the frame rate until an end command.
// - Continuous mode is selected after reset.
// - Burst and continuous: trigger-wait first, then capture-allowed, then frames.
// - End or abort while capture is allowed clears capture and stops.
// - Burst frame tally resets to zero on a forced stop.
// - Frame window follows capture-allowed with frame triggering off, else exposure and readout.
// - Abort acts during trigger waiting, exposure or readout, by sequencer state.
// - Abort during readout lets readout finish, then clears capture-allowed.
// - Abort during exposure finishes exposure, suppresses output, clears capture.
// - Abort while waiting for a trigger clears capture immediately.
// - Free-run frame period is a programmed line count, exposure may exceed it.
// - Frame period ranges from the region minimum up to 0.5 seconds.
// - Minimum frame period comes from the region readout line count.
// - Programmed frame period is ignored with frame triggering on.
// - Exposure longer than the period stretches the period.
// - With start triggering on, capture waits for the start trigger after start.
// - With end triggering on, the end trigger clears capture-allowed.
`timescale 1ns/1ps
module acqsq_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address channel
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data and response channels
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Trigger pulses and sequencer status
  input wire acqsq_pkg::acqsq_trig_t trig_in,
  output acqsq_pkg::acqsq_status_t status_out
);
  import acqsq_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ARM, ST_WAIT, ST_EXPOSE, ST_READ} acqsq_state_t;

  // Byte lane merge for register writes
  function automatic logic [31:0] acqsq_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Address is mapped to a register
  function automatic logic acqsq_mapped(input logic [7:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_CMD) || (a == ADDR_BURST) || (a == ADDR_PERIOD) ||
           (a == ADDR_ROI) || (a == ADDR_EXPO) || (a == ADDR_STATUS) || (a == ADDR_BLOCK) ||
           (a == ADDR_TALLY);
  endfunction

  // Bus state
  logic aw_have_reg, w_have_reg, bvalid_reg, rvalid_reg, awready_reg, wready_reg, arready_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  // Software settings and command pulses
  acqsq_ctrl_t ctrl_reg;
  logic [7:0] burst_total_reg;
  logic [15:0] period_reg, roi_reg, expo_reg;
  logic cmd_begin_reg, cmd_finish_reg, cmd_cancel_reg;
  // Sequencer state
  acqsq_state_t state_reg, state_next;
  logic [15:0] block_reg, ph_reg, lc_reg;
  logic [7:0] tally_reg, tally_next;
  logic pend_reg, pend_next, first_reg, first_next;
  logic [11:0] div_reg;
  acqsq_status_t status_reg, status_next;

  // Write channel handshakes and decode
  wire aw_take = s_axi_awvalid & awready_reg;
  wire w_take = s_axi_wvalid & wready_reg;
  wire aw_ok = aw_have_reg | aw_take;
  wire w_ok = w_have_reg | w_take;
  wire wr_go = aw_ok & w_ok & ~bvalid_reg;
  wire [7:0] wa = aw_have_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wd = w_have_reg ? wdata_reg : s_axi_wdata;
  wire [3:0] ws = w_have_reg ? wstrb_reg : s_axi_wstrb;
  wire aw_have_n = aw_ok & ~wr_go;
  wire w_have_n = w_ok & ~wr_go;
  wire bvalid_n = wr_go | (bvalid_reg & ~s_axi_bready);
  wire wr_ctrl = wr_go & (wa == ADDR_CTRL);
  wire wr_cmd = wr_go & (wa == ADDR_CMD) & ws[0];
  wire wr_burst = wr_go & (wa == ADDR_BURST);
  wire wr_period = wr_go & (wa == ADDR_PERIOD);
  wire wr_roi = wr_go & (wa == ADDR_ROI);
  wire wr_expo = wr_go & (wa == ADDR_EXPO);
  wire [31:0] burst_m = acqsq_merge({24'h0, burst_total_reg}, wd, ws);
  wire [31:0] period_m = acqsq_merge({16'h0, period_reg}, wd, ws);
  wire [31:0] roi_m = acqsq_merge({16'h0, roi_reg}, wd, ws);
  wire [31:0] expo_m = acqsq_merge({16'h0, expo_reg}, wd, ws);
  wire [31:0] ctrl_m = acqsq_merge({26'h0, ctrl_reg}, wd, ws);
  wire [15:0] period_w = (period_m[31:16] != 16'h0 || period_m[15:0] > MAX_PERIOD_LINES) ?
                         MAX_PERIOD_LINES : period_m[15:0];

  // Read channel handshakes and data select
  wire ar_take = s_axi_arvalid & arready_reg;
  wire rvalid_n = ar_take | (rvalid_reg & ~s_axi_rready);
  wire [31:0] rd_mux =
    (s_axi_araddr == ADDR_CTRL) ? {26'h0, ctrl_reg} :
    (s_axi_araddr == ADDR_BURST) ? {24'h0, burst_total_reg} :
    (s_axi_araddr == ADDR_PERIOD) ? {16'h0, period_reg} :
    (s_axi_araddr == ADDR_ROI) ? {16'h0, roi_reg} :
    (s_axi_araddr == ADDR_EXPO) ? {16'h0, expo_reg} :
    (s_axi_araddr == ADDR_STATUS) ? {26'h0, status_reg} :
    (s_axi_araddr == ADDR_BLOCK) ? {16'h0, block_reg} :
    (s_axi_araddr == ADDR_TALLY) ? {24'h0, tally_reg} : 32'h0;

  // AXI4-Lite slave registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rresp_reg <= 2'h0;
      awaddr_reg <= 8'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      rdata_reg <= 32'h0;
    end else begin
      aw_have_reg <= aw_have_n;
      w_have_reg <= w_have_n;
      bvalid_reg <= bvalid_n;
      awready_reg <= ~aw_have_n & ~bvalid_n;
      wready_reg <= ~w_have_n & ~bvalid_n;
      arready_reg <= ~rvalid_n;
      rvalid_reg <= rvalid_n;
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        bresp_reg <= acqsq_mapped(wa) ? 2'h0 : 2'h2;
      end
      if (ar_take) begin
        rdata_reg <= rd_mux;
        rresp_reg <= acqsq_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      end
    end
  end

  // Settings written by software; commands become one-cycle pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      burst_total_reg <= BURST_RESET;
      period_reg <= PERIOD_RESET;
      roi_reg <= ROI_RESET;
      expo_reg <= EXPO_RESET;
      cmd_begin_reg <= 1'b0;
      cmd_finish_reg <= 1'b0;
      cmd_cancel_reg <= 1'b0;
    end else begin
      cmd_begin_reg <= wr_cmd & wd[CMD_BEGIN_BIT];
      cmd_finish_reg <= wr_cmd & wd[CMD_FINISH_BIT];
      cmd_cancel_reg <= wr_cmd & wd[CMD_CANCEL_BIT];
      if (wr_ctrl) begin
        ctrl_reg <= acqsq_ctrl_t'(ctrl_m[5:0]);
      end
      if (wr_burst && burst_m[7:0] >= BURST_MIN) begin
        burst_total_reg <= burst_m[7:0];
      end
      if (wr_period) begin
        period_reg <= period_w;
      end
      if (wr_roi && roi_m[15:0] != 16'h0) begin
        roi_reg <= roi_m[15:0];
      end
      if (wr_expo && expo_m[15:0] != 16'h0) begin
        expo_reg <= expo_m[15:0];
      end
    end
  end

  // Command decode: abort wins over a simultaneous end
  wire cancel_p = cmd_cancel_reg;
  wire finish_p = cmd_finish_reg & ~cmd_cancel_reg;
  wire end_ev = finish_p | (ctrl_reg.end_trig_en & trig_in.end_trig);
  wire frame_trig_on = ctrl_reg.frame_trig_en;

  // Frame period: region minimum, programmed lines, stretched by exposure
  wire [15:0] per_floor = (period_reg < roi_reg) ? roi_reg : period_reg;
  wire [16:0] need_lines = {1'b0, expo_reg} + {1'b0, roi_reg};
  wire [16:0] eff_period = (need_lines > {1'b0, per_floor}) ? need_lines : {1'b0, per_floor};
  wire line_tick = (div_reg == 12'(LINE_CYCLES - 1));
  wire expo_done = line_tick & (ph_reg == expo_reg - 16'h1);
  wire read_done = line_tick & (ph_reg == roi_reg - 16'h1);
  wire free_due = first_reg | ({1'b0, lc_reg} >= eff_period);
  wire frame_go = frame_trig_on ? trig_in.frame_trig : free_due;
  wire last_burst = (ctrl_reg.mode == MODE_BURST) && (tally_reg + 8'h1 >= burst_total_reg);
  wire stop_after = (ctrl_reg.mode == MODE_SINGLE) || last_burst;
  wire forced_stop = (state_reg != ST_IDLE) && (state_next == ST_IDLE) &&
                     (cancel_p | end_ev | pend_reg);
  wire frame_new = (state_reg == ST_WAIT) && (state_next == ST_EXPOSE);
  wire in_capture = (state_next == ST_WAIT) || (state_next == ST_EXPOSE) ||
                    (state_next == ST_READ);

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    pend_next = pend_reg;
    first_next = first_reg;
    tally_next = tally_reg;
    case (state_reg)
      ST_IDLE: begin
        pend_next = 1'b0;
        if (cmd_begin_reg && !cancel_p && !finish_p) begin
          state_next = ST_ARM;
          tally_next = 8'h0;
        end
      end
      ST_ARM: begin
        if (cancel_p || end_ev) begin
          state_next = ST_IDLE;
        end else if (!ctrl_reg.start_trig_en || trig_in.start_trig) begin
          state_next = ST_WAIT;
          first_next = 1'b1;
        end
      end
      ST_WAIT: begin
        if (cancel_p || end_ev) begin
          state_next = ST_IDLE;
        end else if (frame_go) begin
          state_next = ST_EXPOSE;
          first_next = 1'b0;
        end
      end
      ST_EXPOSE: begin
        if (end_ev && !cancel_p) begin
          state_next = ST_IDLE;
        end else if (expo_done) begin
          state_next = (pend_reg || cancel_p) ? ST_IDLE : ST_READ;
        end else if (cancel_p) begin
          pend_next = 1'b1;
        end
      end
      ST_READ: begin
        if (end_ev && !cancel_p) begin
          state_next = ST_IDLE;
        end else if (read_done) begin
          tally_next = tally_reg + 8'h1;
          state_next = (pend_reg || cancel_p || stop_after) ? ST_IDLE : ST_WAIT;
        end else if (cancel_p) begin
          pend_next = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Forced stop decoded in place so this process never reads its own output through a wire
    if ((state_reg != ST_IDLE) && (state_next == ST_IDLE) &&
        (cancel_p || end_ev || pend_reg)) begin
      tally_next = 8'h0;
    end
  end

  // Status flags as they will stand after this edge
  always_comb begin
    status_next = STATUS_RESET;
    status_next.capture_allowed_flag = in_capture;
    status_next.arm_wait_flag = (state_next == ST_ARM);
    status_next.exposing = (state_next == ST_EXPOSE);
    status_next.reading_out = (state_next == ST_READ);
    status_next.frame_window_flag = frame_trig_on ?
      ((state_next == ST_EXPOSE) || (state_next == ST_READ)) : in_capture;
    // A readout that runs on under abort still streams its frame
    status_next.frame_out = (state_reg == ST_READ) && read_done && !(end_ev && !cancel_p);
  end

  // Sequencer registers and line divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      pend_reg <= 1'b0;
      first_reg <= 1'b0;
      tally_reg <= 8'h0;
      block_reg <= 16'h0;
      div_reg <= 12'h0;
      ph_reg <= 16'h0;
      lc_reg <= 16'h0;
      status_reg <= STATUS_RESET;
    end else begin
      state_reg <= state_next;
      pend_reg <= pend_next;
      first_reg <= first_next;
      tally_reg <= tally_next;
      status_reg <= status_next;
      div_reg <= line_tick ? 12'h0 : div_reg + 12'h1;
      if (finish_p) begin
        block_reg <= 16'h0;
      end else if (state_reg == ST_IDLE && state_next == ST_ARM &&
                   !ctrl_reg.paired_exposure_mode) begin
        block_reg <= block_reg + 16'h1;
      end
      if (frame_new || state_next != state_reg) begin
        ph_reg <= 16'h0;
      end else if (line_tick) begin
        ph_reg <= ph_reg + 16'h1;
      end
      if (frame_new) begin
        lc_reg <= 16'h0;
      end else if (line_tick && lc_reg != 16'hFFFF) begin
        lc_reg <= lc_reg + 16'h1;
      end
    end
  end

  // Output drive
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign status_out = status_reg;

  // Checks on the sequencer
  chk_single_one_frame: assert property (@(posedge aclk) disable iff (!aresetn)
    (status_reg.frame_out && $past(ctrl_reg.mode) == MODE_SINGLE) |->
      !status_reg.capture_allowed_flag)
    else $error("capture still allowed after one-shot frame");
  chk_block_count: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_IDLE && cmd_begin_reg && !cmd_cancel_reg && !cmd_finish_reg &&
     !ctrl_reg.paired_exposure_mode) |=> (block_reg == $past(block_reg) + 16'h1))
    else $error("block number did not step on start");
  chk_burst_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    (status_reg.frame_out && $past(ctrl_reg.mode) == MODE_BURST &&
     tally_reg == $past(burst_total_reg)) |-> !status_reg.capture_allowed_flag)
    else $error("burst did not stop at frame total");
  chk_burst_range: assert property (@(posedge aclk) disable iff (!aresetn)
    burst_total_reg >= BURST_MIN)
    else $error("burst frame total out of range");
  chk_arm_before_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(status_reg.capture_allowed_flag) |-> $past(status_reg.arm_wait_flag))
    else $error("capture allowed without trigger wait first");
  chk_end_stops: assert property (@(posedge aclk) disable iff (!aresetn)
    (finish_p && status_reg.capture_allowed_flag) |=> !status_reg.capture_allowed_flag)
    else $error("end command did not clear capture");
  chk_tally_forced: assert property (@(posedge aclk) disable iff (!aresetn)
    forced_stop |=> (tally_reg == 8'h0))
    else $error("tally not cleared on forced stop");
  chk_window_free: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ctrl_reg.frame_trig_en && $stable(ctrl_reg)) |->
      (status_reg.frame_window_flag == status_reg.capture_allowed_flag))
    else $error("frame window differs from capture in free run");
  chk_cancel_wait: assert property (@(posedge aclk) disable iff (!aresetn)
    (cancel_p && (state_reg == ST_ARM || state_reg == ST_WAIT)) |=>
      (!status_reg.capture_allowed_flag && !status_reg.arm_wait_flag))
    else $error("abort while waiting did not clear at once");
  chk_period_max: assert property (@(posedge aclk) disable iff (!aresetn)
    period_reg <= MAX_PERIOD_LINES)
    else $error("frame period above maximum");
endmodule // acqsq_top

// ### sim/acqsq_host.sv
// Host model that drives register accesses and commands over AXI4-Lite
`timescale 1ns/1ps
module acqsq_host (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  // Read channels
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid
);
  // Idle bus at time zero
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wvalid = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
  end
  // One write; each command is a single word, so it becomes a single pulse
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        done = 1'b1;
      end
    end
  endtask
  // One read; bready and rready are held high by the bench
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        resp = s_axi_rresp;
        done = 1'b1;
      end
    end
  endtask
endmodule // acqsq_host

// ### sim/tb_top.sv
// Self-checking bench for the acquisition sequencer
`timescale 1ns/1ps
module tb_top;
  import acqsq_pkg::*;
  // Clock, reset and bus wiring
  logic aclk;
  logic aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  acqsq_trig_t trig_in;
  acqsq_status_t status_out;
  // Bench model and bookkeeping
  int num_errors = 0;
  int checks = 0;
  int nframes = 0;
  int exp_block = 0;
  int base;
  logic [31:0] lfsr = 32'h46CE;
  logic [31:0] d;
  logic [1:0] r;
  logic [7:0] nb;

  acqsq_top acqsq_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .trig_in,
    .status_out);
  acqsq_host acqsq_host_i (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);

  // 125 MHz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Pseudo-random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Compare tasks
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    cmp_val({31'h0, got}, {31'h0, exp});
  endtask
  task automatic cmp_reg(input logic [7:0] a, input logic [31:0] exp);
    acqsq_host_i.rd(a, d, r);
    cmp_val({30'h0, r}, 32'h0);
    cmp_val(d, exp);
  endtask
  // Register write with OKAY response expected
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    acqsq_host_i.wr(a, v, r);
    cmp_val({30'h0, r}, 32'h0);
  endtask
  task automatic begin_cmd;
    wreg(ADDR_CMD, 32'h1);
    exp_block++;
  endtask
  // Bounded waits on a status bit and on the frame count
  task automatic wait_bit(input int b, input logic v);
    int n;
    n = 0;
    while (status_out[b] !== v && n < 40000) begin
      @(posedge aclk);
      n++;
    end
    cmp_flag(status_out[b], v);
  endtask
  task automatic wait_frames(input int f);
    int n;
    n = 0;
    while (nframes < f && n < 40000) begin
      @(posedge aclk);
      n++;
    end
    cmp_val(32'(nframes), 32'(f));
  endtask
  task automatic settle;
    repeat (3) @(posedge aclk);
  endtask
  task automatic pulse(input int b);
    trig_in[b] <= 1'b1;
    @(posedge aclk);
    trig_in[b] <= 1'b0;
  endtask
  task automatic test_end(input string s);
    $display("test %s done, errors %0d", s, num_errors);
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Frame counter and window check; frame triggering stays off
  always @(posedge aclk) begin
    if (aresetn === 1'b1 && status_out.frame_out === 1'b1) begin
      nframes <= nframes + 1;
    end
  end
  always @(negedge aclk) begin
    if (aresetn === 1'b1) begin
      cmp_flag(status_out.frame_window_flag, status_out.capture_allowed_flag);
    end
  end
  // Watchdog
  initial begin
    repeat (90000) @(posedge aclk);
    num_errors++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    aresetn = 1'b0;
    trig_in = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    cmp_reg(ADDR_CTRL, 32'h2);
    cmp_reg(ADDR_STATUS, 32'h0);
    acqsq_host_i.rd(8'h24, d, r);
    cmp_val({30'h0, r}, 32'h2);
    wreg(ADDR_EXPO, 32'h1);
    wreg(ADDR_ROI, 32'h1);
    wreg(ADDR_PERIOD, 32'h1);
    wreg(ADDR_BURST, 32'h0);
    cmp_reg(ADDR_BURST, 32'h1);
    wreg(ADDR_BURST, 32'hFF);
    cmp_reg(ADDR_BURST, 32'hFF);
    test_end("reset");
    wreg(ADDR_CTRL, {30'h0, MODE_SINGLE});
    begin_cmd();
    wait_bit(0, 1'b1);
    wait_bit(0, 1'b0);
    repeat (2) @(posedge aclk);
    cmp_val(32'(nframes), 32'h1);
    cmp_reg(ADDR_TALLY, 32'h1);
    cmp_reg(ADDR_BLOCK, 32'(exp_block));
    test_end("single");
    lfsr = lfsr_next(lfsr);
    nb = 8'h02 + {7'h0, lfsr[0]};
    wreg(ADDR_BURST, {24'h0, nb});
    wreg(ADDR_CTRL, {30'h0, MODE_BURST});
    base = nframes;
    begin_cmd();
    wait_bit(1, 1'b1);
    cmp_flag(status_out.capture_allowed_flag, 1'b0);
    wait_bit(0, 1'b1);
    wait_bit(0, 1'b0);
    repeat (2) @(posedge aclk);
    cmp_val(32'(nframes - base), {24'h0, nb});
    cmp_reg(ADDR_TALLY, {24'h0, nb});
    cmp_reg(ADDR_BLOCK, 32'(exp_block));
    test_end("burst");
    wreg(ADDR_CTRL, {30'h0, MODE_CONT});
    begin_cmd();
    wait_frames(nframes + 2);
    wreg(ADDR_CMD, 32'h2);
    exp_block = 0;
    settle();
    cmp_flag(status_out.capture_allowed_flag, 1'b0);
    cmp_reg(ADDR_BLOCK, 32'(exp_block));
    cmp_reg(ADDR_TALLY, 32'h0);
    test_end("continuous");
    wreg(ADDR_CTRL, {30'h0, MODE_BURST});
    wreg(ADDR_EXPO, 32'h2);
    wreg(ADDR_ROI, 32'h2);
    begin_cmd();
    wait_bit(4, 1'b1);
    base = nframes;
    wreg(ADDR_CMD, 32'h4);
    settle();
    cmp_flag(status_out.capture_allowed_flag, 1'b1);
    wait_bit(0, 1'b0);
    cmp_flag(status_out.reading_out, 1'b0);
    repeat (2) @(posedge aclk);
    cmp_val(32'(nframes - base), 32'h1);
    cmp_reg(ADDR_TALLY, 32'h0);
    test_end("cancel in readout");
    wreg(ADDR_CTRL, {30'h0, MODE_BURST});
    begin_cmd();
    wait_bit(3, 1'b1);
    base = nframes;
    wreg(ADDR_CMD, 32'h4);
    settle();
    cmp_flag(status_out.capture_allowed_flag, 1'b1);
    wait_bit(0, 1'b0);
    cmp_flag(status_out.reading_out, 1'b0);
    cmp_val(32'(nframes - base), 32'h0);
    cmp_reg(ADDR_TALLY, 32'h0);
    test_end("cancel in exposure");
    wreg(ADDR_CTRL, 32'hE);
    begin_cmd();
    wait_bit(1, 1'b1);
    settle();
    cmp_flag(status_out.capture_allowed_flag, 1'b0);
    wreg(ADDR_CMD, 32'h4);
    settle();
    cmp_val({30'h0, status_out[1:0]}, 32'h0);
    begin_cmd();
    wait_bit(1, 1'b1);
    pulse(2);
    settle();
    cmp_flag(status_out.capture_allowed_flag, 1'b1);
    pulse(1);
    settle();
    cmp_flag(status_out.capture_allowed_flag, 1'b0);
    cmp_reg(ADDR_BLOCK, 32'(exp_block));
    test_end("triggers");
    report_and_stop();
  end
endmodule // tb_top
